// *** hw/fcg_clock_gen_config.sv ***
// configuration, status and loop model of the clock generator, reached over classic wishbone
// How it works
// - after reset the generator is self-clocked, about 8 MHz output, 4 MHz bus
// - bus frequency is always half the generator output frequency
// - loop-engaged external mode gives output = reference times P times N divided by R
// - control one bit 6 selects low range with P 64 or high range with P 1
// - control one bits 4:3 written 11 select loop-engaged external mode
// - control one bit 5 set requests a crystal or resonator oscillator
// - control one bit 7 clear selects the low-power oscillator
// - control one bit 2 clear keeps the oscillator off in stop
// - control one bit 1 clear enables loss-of-reference detection
// - control one bit 0 is unimplemented and reads zero
// - control two bit 7 clear makes loss of lock an interrupt, not reset
// - control two bit 3 clear makes reference loss an interrupt, not reset
// - multiply code 000 means factor 4, 011 means factor 10
// - reduce code 000 divides the loop output by one
// - status one is read-only; a write clears the interrupt flag
// - filter bits 15:12 read zero; bits 11:0 are adjusted by the loop
// - mode status follows a mode-select write only after several bus cycles
// - while first locking or relocking after a multiply change, output is divided by 2R
//
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module fcg_clock_gen_config #(
    parameter int unsigned MODE_SETTLE = fcg_pkg::MODE_SETTLE_CYC,
    parameter int unsigned LOOP_STEP   = fcg_pkg::LOOP_STEP_CYC
) (
    // clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          srst,
    // wishbone slave
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [fcg_pkg::ADDR_W-1:0]    wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [31:0]                   wb_dat_i,
    output logic      [31:0]                   wb_dat_o,
    output logic                               wb_ack_o,
    // reference oscillator status
    input  wire logic                          ref_clk_present,
    input  wire logic [15:0]                   ext_ref_khz,
    // oscillator controls
    output logic                               osc_high_gain,
    output logic                               osc_high_range,
    output logic                               osc_request,
    output logic                               osc_stop_enable,
    output logic      [7:0]                    osc_trim,
    // generator results and events
    output logic      [fcg_pkg::FREQ_W-1:0]    generator_output_khz,
    output logic      [fcg_pkg::FREQ_W-1:0]    bus_khz,
    output logic                               loop_locked,
    output logic                               clock_irq,
    output logic                               clock_reset_req
);
    import fcg_pkg::*;

    // ==========================================================
    // registers and state
    logic [7:0]          ctrl_one_q;
    logic [7:0]          ctrl_two_q;
    logic [7:0]          trim_q;
    logic [FILTER_W-1:0] filter_q;
    logic                gain_written_q;
    logic                mult_change_q;
    fcg_mode_type        mode_status_q;
    logic [7:0]          settle_cnt_q;
    fcg_loop_type        loop_q;
    fcg_loop_type        loop_d;
    logic [7:0]          step_cnt_q;
    logic                half_rate_q;
    logic                ref_lost_q;
    logic                clk_loss_flag_q;
    logic                lock_loss_flag_q;
    logic                irq_flag_q;
    logic                irq_q;
    logic                rst_req_q;
    logic                ack_q;
    logic [31:0]         dat_q;
    logic [FILTER_W-1:0] target;
    logic [FREQ_W-1:0]   out_khz;
    logic [FREQ_W-1:0]   bus_khz_w;

    // ==========================================================
    // bus decode
    logic                bus_req;
    logic                bus_wr;
    logic                wr_ctrl_one;
    logic                wr_ctrl_two;
    logic                wr_status_one;
    logic                wr_filter_lo;
    logic                wr_filter_hi;
    logic                wr_trim;
    fcg_mode_type        mode_sel;
    logic                uses_ext;
    logic                loop_engaged;
    logic                ref_missing;
    logic                clk_loss_evt;
    logic                lock_loss_evt;
    logic                mult_change;

    always_comb begin
        bus_req       = wb_cyc_i & wb_stb_i & ~ack_q;
        bus_wr        = bus_req & wb_we_i;
        wr_ctrl_one   = bus_wr & (wb_adr_i == OFS_CTRL_ONE) & wb_sel_i[0];
        wr_ctrl_two   = bus_wr & (wb_adr_i == OFS_CTRL_TWO) & wb_sel_i[0];
        wr_status_one = bus_wr & (wb_adr_i == OFS_STATUS_ONE);
        wr_filter_lo  = bus_wr & (wb_adr_i == OFS_FILTER) & wb_sel_i[0];
        wr_filter_hi  = bus_wr & (wb_adr_i == OFS_FILTER) & wb_sel_i[1];
        wr_trim       = bus_wr & (wb_adr_i == OFS_TRIM) & wb_sel_i[0];
        mode_sel      = fcg_mode_type'(ctrl_one_q[C1_MODE_HI:C1_MODE_LO]);
        uses_ext      = (mode_status_q == FCG_MODE_FBE) | (mode_status_q == FCG_MODE_EXT_LOOP);
        loop_engaged  = (mode_status_q == FCG_MODE_EXT_LOOP) | (mode_status_q == FCG_MODE_FEI);
        ref_missing   = ~ctrl_one_q[C1_LOSS_DIS_BIT] & uses_ext & ~ref_clk_present;
        clk_loss_evt  = ref_missing & ~ref_lost_q;
        mult_change   = wr_ctrl_two & (wb_dat_i[C2_MULT_HI:C2_MULT_LO] != ctrl_two_q[C2_MULT_HI:C2_MULT_LO]);
        lock_loss_evt = (loop_q == FCG_LOOP_LOCKED) & (loop_d != FCG_LOOP_LOCKED) & ~mult_change;
    end

    // ==========================================================
    // control register one
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_one_q     <= CTRL_ONE_RST;
            gain_written_q <= 1'b0;
        end else if (wr_ctrl_one) begin
            // high gain may be chosen only once per reset
            ctrl_one_q[C1_GAIN_BIT]       <= gain_written_q ? ctrl_one_q[C1_GAIN_BIT] : wb_dat_i[C1_GAIN_BIT];
            ctrl_one_q[C1_RANGE_BIT]      <= wb_dat_i[C1_RANGE_BIT];
            ctrl_one_q[C1_XTAL_BIT]       <= wb_dat_i[C1_XTAL_BIT];
            ctrl_one_q[C1_MODE_HI:C1_MODE_LO] <= wb_dat_i[C1_MODE_HI:C1_MODE_LO];
            ctrl_one_q[C1_STOP_EN_BIT]    <= wb_dat_i[C1_STOP_EN_BIT];
            ctrl_one_q[C1_LOSS_DIS_BIT]   <= wb_dat_i[C1_LOSS_DIS_BIT];
            ctrl_one_q[0]                 <= 1'b0;
            gain_written_q                <= 1'b1;
        end
    end

    // ==========================================================
    // control register two, trim
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_two_q <= CTRL_TWO_RST;
        end else if (wr_ctrl_two) begin
            ctrl_two_q <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            trim_q <= TRIM_RST;
        end else if (wr_trim) begin
            trim_q <= wb_dat_i[7:0];
        end
    end

    // ==========================================================
    // mode status lags the selection by a settle count
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mode_status_q <= FCG_MODE_SELF;
            settle_cnt_q  <= '0;
        end else if (mode_sel == mode_status_q) begin
            settle_cnt_q  <= '0;
        end else if (settle_cnt_q == 8'(MODE_SETTLE - 1)) begin
            mode_status_q <= mode_sel;
            settle_cnt_q  <= '0;
        end else begin
            settle_cnt_q  <= settle_cnt_q + 8'h01;
        end
    end

    // ==========================================================
    // loop state
    always_comb begin
        case (loop_q)
            FCG_LOOP_OPEN: begin
                loop_d = loop_engaged ? FCG_LOOP_ACQUIRE : FCG_LOOP_OPEN;
            end
            FCG_LOOP_ACQUIRE: begin
                if (!loop_engaged) begin
                    loop_d = FCG_LOOP_OPEN;
                end else if (filter_q == target && !ref_missing && !mult_change_q) begin
                    loop_d = FCG_LOOP_LOCKED;
                end else begin
                    loop_d = FCG_LOOP_ACQUIRE;
                end
            end
            FCG_LOOP_LOCKED: begin
                if (!loop_engaged) begin
                    loop_d = FCG_LOOP_OPEN;
                end else if (filter_q != target || ref_missing || mult_change) begin
                    loop_d = FCG_LOOP_ACQUIRE;
                end else begin
                    loop_d = FCG_LOOP_LOCKED;
                end
            end
            default: begin
                loop_d = FCG_LOOP_OPEN;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            loop_q <= FCG_LOOP_OPEN;
        end else begin
            loop_q <= loop_d;
        end
    end

    // slow output is kept from entering the loop until lock, and again after a multiply change
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            half_rate_q <= 1'b0;
        end else if ((loop_q == FCG_LOOP_OPEN && loop_d == FCG_LOOP_ACQUIRE) || mult_change) begin
            half_rate_q <= loop_engaged | mult_change;
        end else if (loop_d == FCG_LOOP_LOCKED || !loop_engaged) begin
            half_rate_q <= 1'b0;
        end
    end

    // target is registered, so it lags a multiply write by one cycle;
    // without this the loop would relock on the stale target and then report a lock loss
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mult_change_q <= 1'b0;
        end else begin
            mult_change_q <= mult_change;
        end
    end

    // ==========================================================
    // filter value: stepped by the loop, writable while bypassed
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            filter_q   <= FILTER_RST;
            step_cnt_q <= '0;
        end else if (loop_engaged) begin
            if (ref_missing || filter_q == target) begin
                step_cnt_q <= '0;
            end else if (step_cnt_q == 8'(LOOP_STEP - 1)) begin
                step_cnt_q <= '0;
                filter_q   <= (filter_q < target) ? filter_q + 12'h001 : filter_q - 12'h001;
            end else begin
                step_cnt_q <= step_cnt_q + 8'h01;
            end
        end else begin
            step_cnt_q <= '0;
            if (wr_filter_lo) begin
                filter_q[7:0] <= wb_dat_i[7:0];
            end
            if (wr_filter_hi) begin
                filter_q[FILTER_W-1:8] <= wb_dat_i[FILTER_W-1:8];
            end
        end
    end

    // ==========================================================
    // loss flags, interrupt and reset request
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ref_lost_q <= 1'b0;
        end else begin
            ref_lost_q <= ref_missing;
        end
    end

    // a new event in the clearing cycle stays set
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            clk_loss_flag_q  <= 1'b0;
            lock_loss_flag_q <= 1'b0;
            irq_flag_q       <= 1'b0;
        end else begin
            clk_loss_flag_q  <= clk_loss_evt | (clk_loss_flag_q & ~wr_status_one);
            lock_loss_flag_q <= lock_loss_evt | (lock_loss_flag_q & ~wr_status_one);
            irq_flag_q       <= (clk_loss_evt & ~ctrl_two_q[C2_CLK_RST_BIT])
                              | (lock_loss_evt & ~ctrl_two_q[C2_LOCK_RST_BIT])
                              | (irq_flag_q & ~wr_status_one);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq_q     <= 1'b0;
            rst_req_q <= 1'b0;
        end else begin
            irq_q     <= (clk_loss_evt & ~ctrl_two_q[C2_CLK_RST_BIT])
                       | (lock_loss_evt & ~ctrl_two_q[C2_LOCK_RST_BIT])
                       | (irq_flag_q & ~wr_status_one);
            rst_req_q <= (clk_loss_evt & ctrl_two_q[C2_CLK_RST_BIT])
                       | (lock_loss_evt & ctrl_two_q[C2_LOCK_RST_BIT]);
        end
    end

    // ==========================================================
    // frequency calculation
    fcg_freq_calc u_calc (
        .sys_clk     (sys_clk),
        .srst        (srst),
        .mode        (mode_status_q),
        .high_range  (ctrl_one_q[C1_RANGE_BIT]),
        .mult_code   (ctrl_two_q[C2_MULT_HI:C2_MULT_LO]),
        .reduce_code (ctrl_two_q[C2_DIV_HI:C2_DIV_LO]),
        .half_rate   (half_rate_q),
        .filter      (filter_q),
        .ext_ref_khz (ext_ref_khz),
        .out_khz_q   (out_khz),
        .bus_khz_q   (bus_khz_w),
        .target_q    (target)
    );

    // ==========================================================
    // bus read and acknowledge; unmapped reads return zero
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= bus_req;
            if (bus_req) begin
                case (wb_adr_i)
                    OFS_CTRL_ONE:   dat_q <= {24'h0, ctrl_one_q & C1_WRITE_MASK};
                    OFS_CTRL_TWO:   dat_q <= {24'h0, ctrl_two_q};
                    OFS_STATUS_ONE: dat_q <= {24'h0, mode_status_q, ~ref_missing, clk_loss_flag_q,
                                              loop_q == FCG_LOOP_LOCKED, lock_loss_flag_q, 1'b0, irq_flag_q};
                    OFS_STATUS_TWO: dat_q <= {31'h0, (mode_status_q == FCG_MODE_SELF)
                                              | (mode_status_q == FCG_MODE_FBE)
                                              | (loop_q == FCG_LOOP_LOCKED)};
                    OFS_FILTER:     dat_q <= {20'h0, filter_q};
                    OFS_TRIM:       dat_q <= {24'h0, trim_q};
                    OFS_OUT_FREQ:   dat_q <= {12'h0, out_khz};
                    default:        dat_q <= '0;
                endcase
            end
        end
    end

    // ==========================================================
    // outputs
    assign wb_ack_o             = ack_q;
    assign wb_dat_o             = dat_q;
    assign osc_high_gain        = ctrl_one_q[C1_GAIN_BIT];
    assign osc_high_range       = ctrl_one_q[C1_RANGE_BIT];
    assign osc_request          = ctrl_one_q[C1_XTAL_BIT];
    assign osc_stop_enable      = ctrl_one_q[C1_STOP_EN_BIT];
    assign osc_trim             = trim_q;
    assign generator_output_khz = out_khz;
    assign bus_khz              = bus_khz_w;
    assign loop_locked          = (loop_q == FCG_LOOP_LOCKED);
    assign clock_irq            = irq_q;
    assign clock_reset_req      = rst_req_q;

endmodule // fcg_clock_gen_config

// *** hw/fcg_pkg.sv ***
// constants, field layout and types shared by the clock generator configuration block
package fcg_pkg;

    // ==========================================================
    // clock and register bus
    localparam int unsigned SYS_CLK_HZ       = 100_000_000;
    localparam int unsigned ADDR_W           = 8;

    localparam logic [7:0]  OFS_CTRL_ONE     = 8'h00;
    localparam logic [7:0]  OFS_CTRL_TWO     = 8'h04;
    localparam logic [7:0]  OFS_STATUS_ONE   = 8'h08;
    localparam logic [7:0]  OFS_STATUS_TWO   = 8'h0c;
    localparam logic [7:0]  OFS_FILTER       = 8'h10;
    localparam logic [7:0]  OFS_TRIM         = 8'h14;
    localparam logic [7:0]  OFS_OUT_FREQ     = 8'h18;

    // ==========================================================
    // control register one fields
    localparam int unsigned C1_GAIN_BIT      = 7;
    localparam int unsigned C1_RANGE_BIT     = 6;
    localparam int unsigned C1_XTAL_BIT      = 5;
    localparam int unsigned C1_MODE_HI       = 4;
    localparam int unsigned C1_MODE_LO       = 3;
    localparam int unsigned C1_STOP_EN_BIT   = 2;
    localparam int unsigned C1_LOSS_DIS_BIT  = 1;
    localparam logic [7:0]  C1_WRITE_MASK    = 8'hfe;

    // control register two fields
    localparam int unsigned C2_LOCK_RST_BIT  = 7;
    localparam int unsigned C2_MULT_HI       = 6;
    localparam int unsigned C2_MULT_LO       = 4;
    localparam int unsigned C2_CLK_RST_BIT   = 3;
    localparam int unsigned C2_DIV_HI        = 2;
    localparam int unsigned C2_DIV_LO        = 0;

    // status register one and two fields
    localparam int unsigned S1_MODE_HI       = 7;
    localparam int unsigned S1_MODE_LO       = 6;
    localparam int unsigned S1_REF_OK_BIT    = 5;
    localparam int unsigned S1_CLK_LOSS_BIT  = 4;
    localparam int unsigned S1_LOCK_BIT      = 3;
    localparam int unsigned S1_LOCK_LOSS_BIT = 2;
    localparam int unsigned S1_IRQ_BIT       = 0;
    localparam int unsigned S2_STABLE_BIT    = 0;

    // ==========================================================
    // reset values
    localparam logic [7:0]  CTRL_ONE_RST     = 8'h00;
    localparam logic [7:0]  CTRL_TWO_RST     = 8'h00;
    localparam logic [7:0]  TRIM_RST         = 8'h80;
    localparam int unsigned FILTER_W         = 12;
    localparam logic [11:0] FILTER_RST       = 12'h1f4;

    // ==========================================================
    // frequency model (frequencies in kHz)
    localparam int unsigned FREQ_W           = 20;
    localparam int unsigned FILTER_LSB_KHZ   = 16;
    localparam int unsigned SELF_OUT_KHZ     = 8000;
    localparam int unsigned IRG_KHZ          = 243;
    localparam int unsigned IRG_DIV          = 7;
    localparam int unsigned PRESCALE_LOW     = 64;
    localparam int unsigned PRESCALE_HIGH    = 1;

    // ==========================================================
    // timing
    localparam int unsigned BUS_CLK_DIV      = 2;
    localparam int unsigned MODE_SETTLE_BUS  = 4;
    localparam int unsigned MODE_SETTLE_CYC  = MODE_SETTLE_BUS * BUS_CLK_DIV;
    localparam int unsigned LOOP_STEP_CYC    = 4;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        FCG_MODE_SELF     = 2'b00,
        FCG_MODE_FEI      = 2'b01,
        FCG_MODE_FBE      = 2'b10,
        FCG_MODE_EXT_LOOP = 2'b11
    } fcg_mode_type;

    typedef enum logic [2:0] {
        FCG_LOOP_OPEN    = 3'b001,
        FCG_LOOP_ACQUIRE = 3'b010,
        FCG_LOOP_LOCKED  = 3'b100
    } fcg_loop_type;

    // multiplication factor N from its three-bit code
    function automatic logic [4:0] fcg_mult(input logic [2:0] code);
        fcg_mult = 5'h04 + {1'b0, code, 1'b0};
    endfunction

    // prescale factor P from the range bit
    function automatic logic [6:0] fcg_prescale(input logic high_range);
        fcg_prescale = high_range ? 7'(PRESCALE_HIGH) : 7'(PRESCALE_LOW);
    endfunction

endpackage

// *** hw/fcg_freq_calc.sv ***
// registered output, bus and loop-target frequency calculation
`timescale 1ns/1ns
module fcg_freq_calc (
    // clock and reset
    input  wire logic                           sys_clk,
    input  wire logic                           srst,
    // configuration
    input  wire fcg_pkg::fcg_mode_type          mode,
    input  wire logic                           high_range,
    input  wire logic [2:0]                     mult_code,
    input  wire logic [2:0]                     reduce_code,
    input  wire logic                           half_rate,
    input  wire logic [fcg_pkg::FILTER_W-1:0]   filter,
    input  wire logic [15:0]                    ext_ref_khz,
    // results
    output logic      [fcg_pkg::FREQ_W-1:0]     out_khz_q,
    output logic      [fcg_pkg::FREQ_W-1:0]     bus_khz_q,
    output logic      [fcg_pkg::FILTER_W-1:0]   target_q
);
    import fcg_pkg::*;

    logic [31:0] dco_khz;
    logic [31:0] target_khz;
    logic [31:0] target_code;
    logic [31:0] out_khz;
    logic [3:0]  shift;

    always_comb begin
        dco_khz    = 32'(filter) * 32'(FILTER_LSB_KHZ);
        shift      = {1'b0, reduce_code} + {3'b000, half_rate};
        case (mode)
            FCG_MODE_EXT_LOOP: target_khz = 32'(ext_ref_khz) * 32'(fcg_prescale(high_range)) * 32'(fcg_mult(mult_code));
            FCG_MODE_FEI: target_khz = 32'(IRG_KHZ / IRG_DIV) * 32'(PRESCALE_LOW) * 32'(fcg_mult(mult_code));
            default:      target_khz = 32'h0;
        endcase
        target_code = target_khz / 32'(FILTER_LSB_KHZ);
        if (mode == FCG_MODE_FBE) begin
            out_khz = 32'(ext_ref_khz) >> reduce_code;
        end else begin
            out_khz = dco_khz >> shift;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            out_khz_q <= FREQ_W'(SELF_OUT_KHZ);
            bus_khz_q <= FREQ_W'(SELF_OUT_KHZ / BUS_CLK_DIV);
            target_q  <= '0;
        end else begin
            out_khz_q <= out_khz[FREQ_W-1:0];
            bus_khz_q <= FREQ_W'(out_khz / 32'(BUS_CLK_DIV));
            target_q  <= (target_code > 32'hfff) ? 12'hfff : target_code[FILTER_W-1:0];
        end
    end

endmodule // fcg_freq_calc

// *** tb/fcg_cfg_props.sv ***
// assertion checker for the clock generator configuration block
`timescale 1ns/1ns
module fcg_cfg_props (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        srst,
    // register bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // generator side
    input wire logic        osc_high_range,
    input wire logic        osc_request,
    input wire logic        osc_stop_enable,
    input wire logic [19:0] generator_output_khz,
    input wire logic [19:0] bus_khz,
    input wire logic        loop_locked,
    input wire logic        clock_irq,
    input wire logic        clock_reset_req
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    logic [7:0] c2_q;
    wire tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // shadow of control two, only the reset-enable bits matter here
    always_ff @(posedge sys_clk) begin
        if (srst) c2_q <= 8'h00;
        else if (tk && wb_we_i && wb_adr_i == 8'h04 && wb_sel_i[0]) c2_q <= wb_dat_i[7:0];
    end
    sequence s_w1; tk && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0]; endsequence
    property p_bus_half; bus_khz == (generator_output_khz >> 1); endproperty
    property p_rst_scm; $fell(srst) |-> generator_output_khz == 20'd8000 && bus_khz == 20'd4000; endproperty
    property p_bit0; tk && !wb_we_i && wb_adr_i == 8'h00 |=> wb_dat_o[0] == 1'b0; endproperty
    property p_filt_hi; tk && !wb_we_i && wb_adr_i == 8'h10 |=> wb_dat_o[15:12] == 4'h0; endproperty
    property p_range; s_w1 |=> osc_high_range == $past(wb_dat_i[6]); endproperty
    property p_reference_select; s_w1 |=> osc_request == $past(wb_dat_i[5]); endproperty
    property p_stop; s_w1 |=> osc_stop_enable == $past(wb_dat_i[2]); endproperty
    property p_no_rst; c2_q[7] == 1'b0 && c2_q[3] == 1'b0 |-> !clock_reset_req; endproperty
    a_bus_half: assert property (p_bus_half) else $error("bus rate not half");
    a_rst_scm: assert property (p_rst_scm) else $error("no self-clocked start");
    a_bit0: assert property (p_bit0) else $error("unused bit reads one");
    a_filt_hi: assert property (p_filt_hi) else $error("filter top nibble set");
    a_range: assert property (p_range) else $error("range output wrong");
    a_reference_select: assert property (p_reference_select) else $error("oscillator request wrong");
    a_stop: assert property (p_stop) else $error("stop enable wrong");
    a_no_rst: assert property (p_no_rst) else $error("reset request while disabled");
    c_lock: cover property ($rose(loop_locked));
    c_irq: cover property ($rose(clock_irq));
    c_w1: cover property (s_w1);
endmodule // fcg_cfg_props
bind fcg_clock_gen_config fcg_cfg_props i_props (.*);

// *** tb/fcg_clock_gen_config_tb_top.sv ***
// self-checking bench for the clock generator configuration block
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; $display("Error %0t: got %h exp %h", $time, a, e); end end
module fcg_clock_gen_config_tb_top;
    import fcg_pkg::*;
    logic sys_clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ref_clk_present;
    logic osc_high_gain, osc_high_range, osc_request, osc_stop_enable, loop_locked, clock_irq, clock_reset_req;
    logic [7:0]  wb_adr_i, osc_trim, t;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [15:0] ext_ref_khz;
    logic [19:0] generator_output_khz, bus_khz;
    logic [31:0] exp_q[$], msk_q[$], exp_v, msk_v;
    int n_errors, checked;
    fcg_clock_gen_config #(.MODE_SETTLE(8), .LOOP_STEP(1)) i_fcg_clock_gen_config (.*);
    initial begin
        sys_clk = 0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic report_and_stop;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // a read notes its expectation; the monitor below compares at ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
        int n;
        n = 0;
        if (!w) begin exp_q.push_back(d); msk_q.push_back(m); end
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, 4'h3};
        do begin @(posedge sys_clk); n++; end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin n_errors++; report_and_stop(); end
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge sys_clk);
    endtask
    task automatic wl;
        int n;
        for (n = 0; n < 3000 && loop_locked !== 1'b1; n++) @(posedge sys_clk);
        if (n >= 3000) begin n_errors++; report_and_stop(); end
        // the output register catches up with the lock one edge later
        repeat (2) @(posedge sys_clk);
    endtask
    always @(posedge sys_clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            exp_v = exp_q.pop_front();
            msk_v = msk_q.pop_front();
            `CHK(wb_dat_o & msk_v, exp_v)
        end
    end
    initial begin
        {srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {1'b1, 47'h0};
        ref_clk_present = 1;
        ext_ref_khz = 16'd32;
        t = 8'($urandom(71));
        repeat (5) @(posedge sys_clk);
        srst <= 0;
        @(posedge sys_clk);
        wb(0, OFS_OUT_FREQ, 32'd8000, '1);
        wb(0, OFS_TRIM, 32'h80, '1);
        t = 8'($urandom);
        wb(1, OFS_TRIM, {24'h0, t}, 0);
        `CHK(osc_trim, t)
        wb(0, OFS_TRIM, {24'h0, t}, '1);
        wb(0, 8'h1c, 0, '1);
        wb(1, OFS_CTRL_ONE, 32'h39, 0);
        wb(0, OFS_STATUS_ONE, 0, 32'hc0);
        wb(0, OFS_CTRL_ONE, 32'h38, '1);
        `CHK({osc_high_gain, osc_high_range, osc_request, osc_stop_enable}, 4'b0010)
        wl();
        `CHK(generator_output_khz, 20'd8192)
        `CHK(bus_khz, 20'd4096)
        wb(0, OFS_STATUS_TWO, 32'h1, '1);
        wb(0, OFS_STATUS_ONE, 32'hc0, 32'hc0);
        wb(1, OFS_CTRL_TWO, 32'h30, 0);
        `CHK(generator_output_khz < 20'd8192, 1'b1)
        wl();
        `CHK(generator_output_khz, 20'd20480)
        `CHK(clock_irq, 1'b0)
        wb(0, OFS_CTRL_ONE, 32'h38, '1);
        wb(0, OFS_FILTER, 32'd1280, '1);
        ref_clk_present <= 0;
        repeat (3) @(posedge sys_clk);
        `CHK(clock_irq, 1'b1)
        ref_clk_present <= 1;
        wl();
        wb(1, OFS_STATUS_ONE, 32'hff, 0);
        wb(0, OFS_STATUS_ONE, 32'hc0, 32'hd1);
        `CHK(clock_irq, 1'b0)
        wb(1, OFS_CTRL_TWO, 32'h38, 0);
        ref_clk_present <= 0;
        repeat (2) @(posedge sys_clk);
        `CHK(clock_reset_req, 1'b1)
        report_and_stop();
    end
endmodule // fcg_clock_gen_config_tb_top
